// [hdl/lkw_defs.vh]
// Constants for the link wake and cable status block
`ifndef LKW_DEFS_VH
`define LKW_DEFS_VH
// Clock rate in kHz, so the cycle counts below stay integer
`define LKW_CLK_KHZ 40000
// Idle time of link power state before it counts as inactive, in ns
`define LKW_LPS_IDLE_NS 2600
// More than 2.6 us is needed, so round up and then add one
`define LKW_LPS_IDLE_CYC ((`LKW_LPS_IDLE_NS * `LKW_CLK_KHZ + 999999) / 1000000 + 1)
// Wake square wave period in system-clock cycles, and its half
`define LKW_WAKE_PERIOD 8
`define LKW_WAKE_HALF 4
// Interrupt source positions in status, enable and clear
`define LKW_IRQ_WAKE_ON 0
`define LKW_IRQ_WAKE_OFF 1
`define LKW_IRQ_CABLE 2
`define LKW_IRQ_PWR 3
`define LKW_IRQ_N 4
// Register offsets
`define LKW_REG_CTRL 4'h0
`define LKW_REG_STAT 4'h1
`define LKW_REG_IRQ_STAT 4'h2
`define LKW_REG_IRQ_EN 4'h3
`define LKW_REG_IRQ_CLR 4'h4
// Control field positions
`define LKW_CTRL_LINK_ACTIVE 0
`define LKW_CTRL_RESUME_EN 1
`define LKW_CTRL_CONTENDER 2
// Status field positions
`define LKW_STAT_WAKE 0
`define LKW_STAT_LPS_ACTIVE 1
`define LKW_STAT_CABLE_INACT 2
`define LKW_STAT_PWR 3
`define LKW_STAT_CNA_VALID 4
`define LKW_STAT_PKT_CAUSE 5
// Reset values
`define LKW_CTRL_RST 3'h0
`endif

// [hdl/lkw_lps_filter.v]
// Link power state idle filter
`default_nettype none
`include "lkw_defs.vh"
module lkw_lps_filter #(
  parameter IDLE_CYC = `LKW_LPS_IDLE_CYC
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire lpsIn,
  output reg lpsActive_r
);
  localparam CW = 12;
  reg [CW-1:0] lowCnt_r;
  // Count low cycles; inactive only after the full idle time
  always @(posedge clk) begin
    if (!nrst) begin
      lowCnt_r <= {CW{1'b0}};
      lpsActive_r <= 1'b0;
    end else if (ce) begin
      if (lpsIn) begin
        lowCnt_r <= {CW{1'b0}};
        lpsActive_r <= 1'b1;
      end else if (lowCnt_r < IDLE_CYC[CW-1:0]) begin
        lowCnt_r <= lowCnt_r + 1'b1;
      end else begin
        lpsActive_r <= 1'b0;
      end
    end
  end
endmodule // lkw_lps_filter
`default_nettype wire

// [hdl/lkw_wave_gen.v]
// Square wave generator for the wake output
`default_nettype none
`include "lkw_defs.vh"
module lkw_wave_gen #(
  parameter HALF = `LKW_WAKE_HALF
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire run,
  output reg wave_r
);
  reg [3:0] cnt_r;
  // Toggle every half period; held low while idle so a wake starts clean
  always @(posedge clk) begin
    if (!nrst || !run) begin
      cnt_r <= 4'h0;
      wave_r <= 1'b0;
    end else if (ce) begin
      if (cnt_r == HALF[3:0] - 4'h1) begin
        cnt_r <= 4'h0;
        wave_r <= ~wave_r;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // lkw_wave_gen
`default_nettype wire

// [hdl/lkw_link_wake.v]
// Link wake signalling, contender strap and cable status
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
`include "lkw_defs.vh"
module lkw_link_wake #(
  parameter IDLE_CYC = `LKW_LPS_IDLE_CYC
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  // Shared contender strap and wake pin
  input wire contenderWakePinIn,
  output reg contenderWakePinOut,
  output reg contenderWakePinOe,
  // Link side
  input wire linkPowerStateIn,
  input wire wakePacketRx,
  input wire busReset,
  input wire portEventIrqFlag,
  input wire configTimeoutIrqFlag,
  input wire cablePowerChangeIrqFlag,
  input wire stateTimeoutIrqFlag,
  // Analog port sense
  input wire biasDetect,
  input wire cablePowerSenseIn,
  output reg cableInactiveOut,
  output reg cablePowerPresent,
  output reg contenderStatus,
  // Control lines, three signals each
  input wire ctrlLine0In,
  input wire ctrlLine1In,
  input wire [1:0] ctrlDriveVal,
  input wire ctrlDriveEn,
  output reg ctrlLine0Out,
  output reg ctrlLine0Oe,
  output reg ctrlLine1Out,
  output reg ctrlLine1Oe,
  output reg [1:0] ctrlLineLevel,
  // Register port
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  output reg irq
);
  //--------------------------------------------------------------
  // Registers and state
  //--------------------------------------------------------------
  reg inReset_r;
  reg strap_r;
  reg [2:0] ctrl_r;
  reg wakeActive_r;
  reg pktCause_r;
  reg cnaValid_r;
  reg [`LKW_IRQ_N-1:0] irqStat_r;
  reg [`LKW_IRQ_N-1:0] irqEn_r;
  reg [`LKW_IRQ_N-1:0] irqSet;
  reg wakeActive_nxt;
  reg pktCause_nxt;
  reg prevPwr_r;
  reg prevBias_r;
  wire lpsActive;
  wire wave;
  wire linkActive;
  wire irqCause;
  wire [`LKW_IRQ_N-1:0] irqClr;

  lkw_lps_filter #(
    .IDLE_CYC(IDLE_CYC)
  ) uLps (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .lpsIn(linkPowerStateIn),
    .lpsActive_r(lpsActive)
  );

  lkw_wave_gen #(
    .HALF(`LKW_WAKE_HALF)
  ) uWave (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(wakeActive_r),
    .wave_r(wave)
  );

  //--------------------------------------------------------------
  // Wake decision
  //--------------------------------------------------------------
  // Controller counts active only with both power state and bit set
  assign linkActive = lpsActive & ctrl_r[`LKW_CTRL_LINK_ACTIVE];
  // Interrupt causes; evaluated as levels so a pending one fires later
  assign irqCause = portEventIrqFlag |
    (ctrl_r[`LKW_CTRL_RESUME_EN] &
    (configTimeoutIrqFlag | cablePowerChangeIrqFlag | stateTimeoutIrqFlag));

  // Next wake state
  always @* begin
    wakeActive_nxt = wakeActive_r;
    pktCause_nxt = pktCause_r;
    if (linkActive) begin
      wakeActive_nxt = 1'b0;
      pktCause_nxt = 1'b0;
    end else begin
      if (wakePacketRx) begin
        wakeActive_nxt = 1'b1;
        pktCause_nxt = 1'b1;
      end else if (busReset && !irqCause) begin
        wakeActive_nxt = 1'b0;
        pktCause_nxt = 1'b0;
      end
      if (irqCause) begin
        wakeActive_nxt = 1'b1;
      end
    end
  end

  //--------------------------------------------------------------
  // Reset tracking, strap capture and pin drive
  //--------------------------------------------------------------
  // Strap is sampled in the first cycle after reset release; latched value kept after that
  always @(posedge clk) begin
    if (!nrst) begin
      inReset_r <= 1'b1;
      strap_r <= 1'b0;
      contenderWakePinOut <= 1'b0;
      contenderWakePinOe <= 1'b0;
      contenderStatus <= 1'b0;
    end else if (ce) begin
      if (inReset_r) begin
        strap_r <= contenderWakePinIn;
        contenderStatus <= contenderWakePinIn;
        inReset_r <= 1'b0;
      end else begin
        contenderWakePinOe <= 1'b1;
        contenderWakePinOut <= wakeActive_r & wave;
        contenderStatus <= strap_r | ctrl_r[`LKW_CTRL_CONTENDER];
      end
    end
  end

  // Wake state registers
  always @(posedge clk) begin
    if (!nrst) begin
      wakeActive_r <= 1'b0;
      pktCause_r <= 1'b0;
    end else if (ce) begin
      wakeActive_r <= wakeActive_nxt;
      pktCause_r <= pktCause_nxt;
    end
  end

  //--------------------------------------------------------------
  // Cable status
  //--------------------------------------------------------------
  // Not debounced; valid flag only rises after a hard reset completes
  always @(posedge clk) begin
    if (!nrst) begin
      cableInactiveOut <= 1'b0;
      cablePowerPresent <= 1'b0;
      cnaValid_r <= 1'b0;
      prevPwr_r <= 1'b0;
      prevBias_r <= 1'b0;
    end else if (ce) begin
      cnaValid_r <= 1'b1;
      cableInactiveOut <= ~biasDetect;
      cablePowerPresent <= cablePowerSenseIn;
      prevPwr_r <= cablePowerSenseIn;
      prevBias_r <= biasDetect;
    end
  end

  //--------------------------------------------------------------
  // Control lines with registered level
  //--------------------------------------------------------------
  // Undriven lines are not held here; ctrlLineLevel follows the line inputs while undriven and ctrlDriveVal while driven
  always @(posedge clk) begin
    if (!nrst) begin
      ctrlLine0Out <= 1'b0;
      ctrlLine1Out <= 1'b0;
      ctrlLine0Oe <= 1'b0;
      ctrlLine1Oe <= 1'b0;
      ctrlLineLevel <= 2'h0;
    end else if (ce) begin
      ctrlLine0Oe <= ctrlDriveEn;
      ctrlLine1Oe <= ctrlDriveEn;
      if (ctrlDriveEn) begin
        ctrlLine0Out <= ctrlDriveVal[0];
        ctrlLine1Out <= ctrlDriveVal[1];
        ctrlLineLevel <= ctrlDriveVal;
      end else begin
        ctrlLine0Out <= ctrlLine0In;
        ctrlLine1Out <= ctrlLine1In;
        ctrlLineLevel <= {ctrlLine1In, ctrlLine0In};
      end
    end
  end

  //--------------------------------------------------------------
  // Interrupts and register port
  //--------------------------------------------------------------
  // Events: wake rise, wake fall, cable change, power change
  always @* begin
    irqSet = {`LKW_IRQ_N{1'b0}};
    irqSet[`LKW_IRQ_WAKE_ON] = wakeActive_nxt & ~wakeActive_r;
    irqSet[`LKW_IRQ_WAKE_OFF] = ~wakeActive_nxt & wakeActive_r;
    irqSet[`LKW_IRQ_CABLE] = biasDetect ^ prevBias_r;
    irqSet[`LKW_IRQ_PWR] = cablePowerSenseIn ^ prevPwr_r;
  end

  assign irqClr = (regWr && regAddr == `LKW_REG_IRQ_CLR) ?
    regWdata[`LKW_IRQ_N-1:0] : {`LKW_IRQ_N{1'b0}};

  // Set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= `LKW_CTRL_RST;
      irqEn_r <= {`LKW_IRQ_N{1'b0}};
      irqStat_r <= {`LKW_IRQ_N{1'b0}};
      irq <= 1'b0;
      regRdata <= 8'h00;
    end else if (ce) begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqEn_r);
      if (regWr && regAddr == `LKW_REG_CTRL) begin
        ctrl_r <= regWdata[2:0];
      end
      if (regWr && regAddr == `LKW_REG_IRQ_EN) begin
        irqEn_r <= regWdata[`LKW_IRQ_N-1:0];
      end
      regRdata <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `LKW_REG_CTRL: regRdata <= {5'h00, ctrl_r};
          `LKW_REG_STAT: regRdata <= {2'h0, pktCause_r, cnaValid_r, cablePowerPresent,
            cableInactiveOut, lpsActive, wakeActive_r};
          `LKW_REG_IRQ_STAT: regRdata <= {4'h0, irqStat_r};
          `LKW_REG_IRQ_EN: regRdata <= {4'h0, irqEn_r};
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // lkw_link_wake
`default_nettype wire

// [verif/lkw_link_wake_sva.sv]
// Checker for the wake pin, strap and cable status ports
`default_nettype none
`include "lkw_defs.vh"
module lkw_link_wake_sva (
  input wire clk,
  input wire nrst,
  input wire contenderWakePinIn,
  input wire contenderWakePinOut,
  input wire contenderWakePinOe,
  input wire linkPowerStateIn,
  input wire wakePacketRx,
  input wire portEventIrqFlag,
  input wire biasDetect,
  input wire cableInactiveOut,
  input wire contenderStatus,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Link-active bit shadowed from writes, since it is not a port
  reg linkAct_r;
  always @(posedge clk) begin
    if (!nrst) linkAct_r <= 1'b0;
    else if (regWr && regAddr == `LKW_REG_CTRL) linkAct_r <= regWdata[`LKW_CTRL_LINK_ACTIVE];
  end
  wire idle = contenderWakePinOe && !linkAct_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----
  // Properties
  // ----
  sequence s_float_then_drive;
    !contenderWakePinOe ##1 !contenderWakePinOe ##1 contenderWakePinOe;
  endsequence
  a_release_pin_drive: assert property ($rose(nrst) |-> s_float_then_drive)
    else $error("pin drive after reset release wrong");
  a_strap_latched: assert property ($rose(nrst) |=> contenderStatus == $past(contenderWakePinIn))
    else $error("contender strap not latched");
  a_pin_oe_held: assert property (contenderWakePinOe |=> contenderWakePinOe)
    else $error("pin drive dropped");
  a_wave_high_max: assert property (contenderWakePinOut [*4] |=> !contenderWakePinOut)
    else $error("wake high phase too long");
  a_packet_wake: assert property (wakePacketRx && idle |-> ##[1:12] contenderWakePinOut)
    else $error("packet did not wake");
  a_port_wake: assert property (portEventIrqFlag && idle |-> ##[1:12] contenderWakePinOut)
    else $error("port event did not wake");
  a_link_quiet: assert property ((linkAct_r && linkPowerStateIn) [*8] |-> !contenderWakePinOut)
    else $error("wake active with link active");
  a_cna_follow: assert property (1'b1 |=> cableInactiveOut == !$past(biasDetect))
    else $error("cable inactive does not follow bias");
  a_read_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read slot");
endmodule // lkw_link_wake_sva
bind lkw_link_wake lkw_link_wake_sva i_lkw_link_wake_sva (.*);
`default_nettype wire

// [verif/lkw_llc_model.sv]
// Link-layer controller model driving link power state
`default_nettype none
module lkw_llc_model (
  input wire logic clk,
  input wire logic wakePin,
  input wire logic powerCmd,
  input wire logic autoWake,
  output logic lps
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  int rises = 0;
  initial lps = 1'b0;
  // Wakes after two wake edges; a real controller needs a few to notice
  always @(posedge clk) begin
    last <= wakePin;
    rises <= autoWake ? rises + int'(wakePin && !last) : 0;
    lps <= powerCmd || (autoWake && rises >= 2);
  end
endmodule // lkw_llc_model
`default_nettype wire

// [verif/tb_lkw_link_wake.sv]
// Testbench for the link wake and cable status block
`default_nettype none
`include "lkw_defs.vh"
module tb_lkw_link_wake;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, nrst = 0, ce = 1, strapHi = 1, llcEn = 0, powerCmd = 0, autoWake = 0;
  logic contenderWakePinIn, contenderWakePinOut, contenderWakePinOe, linkPowerStateIn;
  logic wakePacketRx = 0, busReset = 0, portEventIrqFlag = 0, configTimeoutIrqFlag = 0;
  logic cablePowerChangeIrqFlag = 0, stateTimeoutIrqFlag = 0, biasDetect = 0;
  logic cablePowerSenseIn = 0, cableInactiveOut, cablePowerPresent, contenderStatus;
  logic ctrlLine0In, ctrlLine1In, ctrlDriveEn = 0, ctrlLine0Out, ctrlLine0Oe, ctrlLine1Out;
  logic ctrlLine1Oe, regWr = 0, regRd = 0, irq, hold0 = 0, hold1 = 0;
  logic [1:0] ctrlDriveVal = 0, ctrlLineLevel, llcVal = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata;
  int bad_count = 0, n_compared = 0, seed = 53557;
  // Short idle filter keeps the run brief
  lkw_link_wake #(.IDLE_CYC(4)) i_lkw_link_wake (.*);
  lkw_llc_model i_lkw_llc_model (.clk(clk), .wakePin(contenderWakePinIn), .powerCmd(powerCmd),
    .autoWake(autoWake), .lps(linkPowerStateIn));
  // Pins resolved here; control lines keep their level when nobody drives
  assign contenderWakePinIn = contenderWakePinOe ? contenderWakePinOut : strapHi;
  assign ctrlLine0In = ctrlLine0Oe ? ctrlLine0Out : llcEn ? llcVal[0] : hold0;
  assign ctrlLine1In = ctrlLine1Oe ? ctrlLine1Out : llcEn ? llcVal[1] : hold1;
  always @(posedge clk) {hold1, hold0} <= {ctrlLine1In, ctrlLine0In};
  always #12.5 clk = ~clk;
  // ----
  // Tasks
  // ----
  task automatic conclude;
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rst(input logic s);
    @(posedge clk);
    nrst <= 1'b0;
    strapHi <= s;
    repeat (12) @(posedge clk);
    #1 chk("pinOe", 0, contenderWakePinOe);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("contender", s, contenderStatus);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdata", e, regRdata & m);
  endtask
  task automatic pulse(input int w);
    @(posedge clk);
    if (w) busReset <= 1'b1;
    else wakePacketRx <= 1'b1;
    @(posedge clk);
    busReset <= 1'b0;
    wakePacketRx <= 1'b0;
  endtask
  // Records the pin, then measures period and high time of the wave
  task automatic wv(input int on);
    logic q[$];
    int r[$];
    int hi;
    hi = 0;
    repeat (48) begin
      @(posedge clk);
      #1 q.push_back(contenderWakePinOut);
    end
    for (int i = 1; i < 48; i++) if (q[i] === 1'b1 && q[i-1] === 1'b0) r.push_back(i);
    if (on) begin
      for (int i = 0; i < 8; i++) hi += (r.size() > 1 && q[r[0]+i] === 1'b1);
      chk("period", `LKW_WAKE_PERIOD, r.size() > 1 ? r[1] - r[0] : 0);
      chk("high", `LKW_WAKE_HALF, hi);
    end else chk("rises", 0, r.size());
    chk("pinOe", 1, contenderWakePinOe);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    rst(1'b1);
    rd(`LKW_REG_STAT, 8'h10, 8'h10);
    wv(0);
    rst(1'b0);
    wr(`LKW_REG_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk("contender", 1, contenderStatus);
    wr(`LKW_REG_CTRL, 8'h00);
    repeat (20) begin
      @(posedge clk);
      biasDetect <= 1'($random(seed));
      cablePowerSenseIn <= 1'($random(seed));
      repeat (2) @(posedge clk);
      #1 chk("cna", !biasDetect, cableInactiveOut);
      chk("cps", cablePowerSenseIn, cablePowerPresent);
    end
    pulse(0);
    wv(1);
    rd(`LKW_REG_STAT, 8'h21, 8'h21);
    rd(`LKW_REG_IRQ_STAT, 8'h01, 8'h01);
    chk("irq", 0, irq);
    wr(`LKW_REG_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq", 1, irq);
    wr(`LKW_REG_IRQ_CLR, 8'h01);
    rd(`LKW_REG_IRQ_STAT, 8'h01, 8'h00);
    chk("irq", 0, irq);
    rd(4'hF, 8'hFF, 8'h00);
    wr(`LKW_REG_IRQ_EN, 8'h00);
    pulse(1);
    wv(0);
    @(posedge clk);
    portEventIrqFlag <= 1'b1;
    wv(1);
    pulse(1);
    wv(1);
    wr(`LKW_REG_CTRL, 8'h01);
    autoWake <= 1'b1;
    repeat (40) @(posedge clk);
    powerCmd <= 1'b1;
    autoWake <= 1'b0;
    wv(0);
    @(posedge clk);
    powerCmd <= 1'b0;
    repeat (2) @(posedge clk);
    powerCmd <= 1'b1;
    wv(0);
    @(posedge clk);
    powerCmd <= 1'b0;
    wv(1);
    @(posedge clk);
    portEventIrqFlag <= 1'b0;
    powerCmd <= 1'b1;
    repeat (20) @(posedge clk);
    powerCmd <= 1'b0;
    wv(0);
    wr(`LKW_REG_CTRL, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {stateTimeoutIrqFlag, cablePowerChangeIrqFlag, configTimeoutIrqFlag} <= 3'(1 << k);
      wv(0);
      wr(`LKW_REG_CTRL, 8'h02);
      wv(1);
      @(posedge clk);
      {stateTimeoutIrqFlag, cablePowerChangeIrqFlag, configTimeoutIrqFlag} <= 3'h0;
      powerCmd <= 1'b1;
      wr(`LKW_REG_CTRL, 8'h03);
      repeat (20) @(posedge clk);
      wr(`LKW_REG_CTRL, 8'h00);
    end
    @(posedge clk);
    llcVal <= 2'($random(seed));
    llcEn <= 1'b1;
    repeat (3) @(posedge clk);
    llcEn <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("ctrl hold", llcVal, ctrlLineLevel);
    @(posedge clk);
    ctrlDriveVal <= ~llcVal;
    ctrlDriveEn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("ctrl oe", 3, {ctrlLine1Oe, ctrlLine0Oe});
    chk("ctrl drive", ctrlDriveVal, ctrlLineLevel);
    chk("ctrl out", ctrlDriveVal, {ctrlLine1Out, ctrlLine0Out});
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule // tb_lkw_link_wake
`default_nettype wire
